/* File: dv/ccb_chk.sv */
// ccb_chk: port assertions for the block
`timescale 1ns/10ps
module ccb_chk (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o,
  input wire ccb_pkg::ccb_sense_s sense_i,
  input wire logic                cc_hv_en_o,
  input wire logic                led_red_o,
  input wire logic                led_green_o,
  input wire logic                nvm_we_o,
  input wire ccb_pkg::ccb_press_t nvm_data_o
);
  import ccb_pkg::*;
  logic      auto_q;
  logic      dflt_q;
  logic      prot_q;
  wire logic wr_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i == 4'hf;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////
  // shadow of auto, protect and default thresholds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_q <= 1'b1;
      dflt_q <= 1'b1;
      prot_q <= 1'b0;
    end else if (wr_w && wb_adr_i == REG_CTRL) begin
      auto_q <= wb_dat_i[CTRL_AUTO];
      prot_q <= wb_dat_i[CTRL_PROT];
    end else if (wr_w && (wb_adr_i == REG_CC_ON || wb_adr_i == REG_CC_OFF)) begin
      dflt_q <= 1'b0;
    end
  end
  ////////////////////////
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  force_off_a: assert property (sense_i.thermal > FORCE_OFF_P |=> !cc_hv_en_o)
    else $error("hv on above force off level");
  auto_on_a: assert property (auto_q && dflt_q && !prot_q && sense_i.thermal < CC_ON_RST
    |=> cc_hv_en_o) else $error("hv not switched on");
  auto_off_a: assert property (auto_q && dflt_q && sense_i.thermal > CC_OFF_RST
    |=> !cc_hv_en_o) else $error("hv not switched off");
  hyst_hold_a: assert property (auto_q && dflt_q && !prot_q && sense_i.thermal >= CC_ON_RST
    && sense_i.thermal <= CC_OFF_RST |=> $stable(cc_hv_en_o)) else $error("hv moved in band");
  led_excl_a: assert property (!(led_red_o && led_green_o))
    else $error("red and green lit together");
  nvm_pulse_a: assert property (nvm_we_o |=> !nvm_we_o && $stable(nvm_data_o))
    else $error("store pulse or data not held");
endmodule : ccb_chk
bind ccb_top ccb_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .sense_i(sense_i), .cc_hv_en_o(cc_hv_en_o), .led_red_o(led_red_o),
  .led_green_o(led_green_o), .nvm_we_o(nvm_we_o), .nvm_data_o(nvm_data_o));

/* File: dv/ccb_head_model.sv */
// ccb_head_model: gauge head driving the sensor inputs
`timescale 1ns/10ps
module ccb_head_model #(
  parameter int IGNITE_CYCLES = 20
) (
  input  wire logic                clk_i,
  input  wire logic                hv_i,
  input  wire logic                plasma_i,
  input  wire ccb_pkg::ccb_press_t thermal_i,
  input  wire ccb_pkg::ccb_press_t ion_i,
  input  wire ccb_pkg::ccb_press_t diff_i,
  output ccb_pkg::ccb_sense_s      sense_o
);
  import ccb_pkg::*;
  int         wait_q = 0;
  ccb_press_t junk_q = 48'h5a5a;
  // discharge starts late, only if allowed
  always @(posedge clk_i) begin
    wait_q <= (!hv_i || !plasma_i) ? 0 : (wait_q < IGNITE_CYCLES ? wait_q + 1 : wait_q);
    junk_q <= ~junk_q + 48'h1235;
  end
  // unignited ion sensor gives noise
  always_comb begin
    sense_o.thermal     = thermal_i;
    sense_o.piezo_diff  = diff_i;
    sense_o.ion_ignited = wait_q == IGNITE_CYCLES;
    sense_o.ion         = sense_o.ion_ignited ? ion_i : junk_q;
  end
endmodule : ccb_head_model

/* File: dv/tb.sv */
// tb: self-checking bench for the control and blend block
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  import ccb_pkg::*;
  localparam int         IGN = 20;
  localparam ccb_press_t DFLT [5] = '{CC_ON_RST, CC_OFF_RST, BLEND_LO_RST, BLEND_HI_RST,
                                      DOSE_SP_RST};
  localparam logic [7:0] BAD_A [8] = '{REG_CC_ON, REG_CC_ON, REG_CC_OFF, REG_BLO, REG_BLO,
                                       REG_BHI, REG_DOSE_SP, REG_DOSE_SP};
  localparam ccb_press_t BAD_V [8] = '{SET_MIN - 1, SET_MAX + 1, CC_ON_RST, SET_MIN - 1,
                                       BLEND_HI_RST + 1, SET_MAX + 1, DOSE_SP_MIN - 1,
                                       DOSE_SP_MAX + 1};
  localparam ccb_press_t HYS_P [5] = '{CC_ON_RST - 1, CC_OFF_RST, CC_OFF_RST + 1, CC_ON_RST,
                                       FORCE_OFF_P + 1};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        plasma = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [3:0]  sel_v = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack, hv, led_r, led_g, nvm_we;
  ccb_press_t  nvm_d;
  ccb_press_t  thermal = ATM_DEF_P;
  ccb_press_t  ion = 48'h0;
  ccb_press_t  diff = 48'h0;
  ccb_sense_s  sense;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  ////////////////////////
  ccb_head_model #(.IGNITE_CYCLES(IGN)) u_head (.clk_i(clk_i), .hv_i(hv), .plasma_i(plasma),
    .thermal_i(thermal), .ion_i(ion), .diff_i(diff), .sense_o(sense));
  ccb_top #(.HALF_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sense_i(sense), .cc_hv_en_o(hv), .led_red_o(led_r),
    .led_green_o(led_g), .nvm_we_o(nvm_we), .nvm_data_o(nvm_d));
  // clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  ////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // one wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= sel_v;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    errors += (n >= 50);
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [7:0] code);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    wb(1'b0, REG_REPLY, 32'h0, q);
    `CHK(q[7:0], code)
  endtask : wr32
  task automatic wr48(input logic [7:0] a, input ccb_press_t v, input logic [7:0] code);
    logic [31:0] q;
    wb(1'b1, REG_STAGE, v[31:0], q);
    wr32(a, {16'h0, v[47:32]}, code);
  endtask : wr48
  task automatic rd48(input logic [7:0] a, output ccb_press_t v, output logic [3:0] dg);
    logic [31:0] lo, hi;
    wb(1'b0, a, 32'h0, lo);
    wb(1'b0, REG_READ_HI, 32'h0, hi);
    v  = {hi[15:0], lo};
    dg = hi[19:16];
  endtask : rd48
  task automatic chk_dflt();
    ccb_press_t  r;
    logic [3:0]  dg;
    for (int i = 0; i < 5; i++) begin
      rd48(REG_CC_ON + 8'(4 * i), r, dg);
      `CHK(r, DFLT[i])
    end
  endtask : chk_dflt
  // watches leds and store pulses over five blink periods
  task automatic watch(output logic [1:0] seen, output logic got, output ccb_press_t d);
    {seen, got, d} = '0;
    repeat (40) begin
      @(posedge clk_i);
      seen |= {led_r === 1'b1, led_g === 1'b1};
      got |= (nvm_we === 1'b1);
      d = (nvm_we === 1'b1) ? nvm_d : d;
    end
  endtask : watch
  function automatic logic near(input ccb_press_t got, input ccb_press_t exp);
    return (got > exp ? got - exp : exp - got) <= (exp >> 12) + 48'h2;
  endfunction : near
  ////////////////////////
  initial begin
    logic [31:0] q;
    ccb_press_t  r, v, hi;
    logic [3:0]  dg;
    logic [1:0]  seen;
    logic        got;
    int          n, t0;
    q = $urandom(32'h0b0f);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // defaults at atmosphere, uncalibrated
    chk_dflt();
    wb(1'b0, REG_CTRL, 32'h0, q);
    `CHK(q[2:0], 3'h1)
    wb(1'b0, REG_PROT, 32'h0, q);
    `CHK(q[9:0], PROT_TIME_RST)
    rd48(REG_RD3, r, dg);
    `CHK({r, dg}, {ATM_DEF_P, DIG3})
    rd48(REG_RD4, r, dg);
    `CHK(dg, DIG4)
    wb(1'b0, 8'hfc, 32'h0, q);
    `CHK(q, 32'h0)
    // thermal wanders across both thresholds
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_i);
      thermal <= ($urandom % 2) ? CC_ON_RST - 48'h2 + ($urandom % 4)
                                : CC_OFF_RST - 48'h2 + ($urandom % (FORCE_OFF_P / 4));
    end
    for (int i = 0; i < 5; i++) begin
      thermal <= HYS_P[i];
      repeat (3) @(posedge clk_i);
      `CHK(hv, i < 2)
    end
    // second reset, then delayed ignition
    rst_i   <= 1'b1;
    thermal <= BLEND_LO_RST / 2;
    ion     <= BLEND_LO_RST / 4;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cycles;
    repeat (30) @(posedge clk_i);
    rd48(REG_RD3, r, dg);
    `CHK(r, BLEND_LO_RST / 2)
    watch(seen, got, r);
    `CHK(seen, 2'b10)
    plasma <= 1'b1;
    repeat (IGN + 50) @(posedge clk_i);
    rd48(REG_RD3, r, dg);
    `CHK(r, BLEND_LO_RST / 4)
    wb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[1:0], 2'h3)
    watch(seen, got, r);
    `CHK(seen, 2'b01)
    // dose against the smallest setpoint
    wr48(REG_DOSE_SP, DOSE_SP_MIN, REPLY_ACK);
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, q);
      n++;
    end while (q[2] !== 1'b1 && n < 1000);
    `CHK(q[2] === 1'b1 && cycles - t0 > 500, 1'b1)
    rd48(REG_DOSE, r, dg);
    `CHK(r > DOSE_SP_MIN, 1'b1)
    wr48(REG_DOSE_SP, DOSE_SP_RST, REPLY_ACK);
    wb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[2], 1'b0)
    // protect trips after three ticks, cleared by a control write
    ion <= FORCE_OFF_P + 1;
    wr32(REG_PROT, 32'h3e8, NAK_RANGE);
    wr32(REG_PROT, 32'h3, REPLY_ACK);
    wr32(REG_CTRL, 32'h5, REPLY_ACK);
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, q);
      n++;
    end while (q[4] !== 1'b1 && n < 100);
    `CHK({q[4], hv, n > 2}, 3'b101)
    ion <= BLEND_LO_RST / 4;
    wr32(REG_CTRL, 32'h1, REPLY_ACK);
    repeat (3) @(posedge clk_i);
    `CHK(hv, 1'b1)
    // rejected settings change nothing
    for (int i = 0; i < 8; i++) begin
      wr48(BAD_A[i], BAD_V[i], NAK_RANGE);
    end
    chk_dflt();
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? SET_MIN : SET_MIN + $urandom % (CC_OFF_RST - SET_MIN);
      wr48(REG_CC_ON, v, REPLY_ACK);
      rd48(REG_CC_ON, r, dg);
      `CHK(r, v)
    end
    wr48(REG_CC_OFF, v + 1, REPLY_ACK);
    hi = BLEND_HI_RST;
    for (int i = 0; i < 3; i++) begin
      v = SET_MIN + $urandom % (hi - SET_MIN + 1);
      wr48(REG_BLO, v, REPLY_ACK);
      rd48(REG_BHI, hi, dg);
      `CHK(near(hi, v * 13 / 10), 1'b1)
    end
    for (int i = 0; i <= 9; i++) begin
      wr32(REG_GAS, 32'(i % 9), REPLY_ACK);
      wb(1'b0, REG_GAS, 32'h0, q);
      `CHK(q[3:0], 4'(i % 9))
    end
    // manual power refused under auto control
    wr32(REG_CTRL, 32'h3, NAK_AUTO);
    wr32(REG_CTRL, 32'h0, REPLY_ACK);
    wr48(REG_CC_ON, CC_ON_RST, NAK_AUTO);
    wr48(REG_CC_OFF, CC_OFF_RST, NAK_AUTO);
    sel_v = 4'h3;
    wr32(REG_CTRL, 32'h2, NAK_AUTO);
    sel_v = 4'hf;
    `CHK(hv, 1'b0)
    wr32(REG_CTRL, 32'h2, REPLY_ACK);
    `CHK(hv, 1'b1)
    thermal <= FORCE_OFF_P + 1;
    repeat (3) @(posedge clk_i);
    `CHK(hv, 1'b0)
    // recalibration, stored only on a large change
    thermal <= CAL_BELOW_P - 1;
    diff    <= 48'h0 - PW'(750 * E10);
    watch(seen, got, r);
    `CHK({got, r}, {1'b1, PW'(750 * E10)})
    diff <= 48'h0 - PW'(755 * E10);
    watch(seen, got, r);
    `CHK(got, 1'b0)
    diff <= 48'h0 - PW'(770 * E10);
    watch(seen, got, r);
    `CHK({got, r}, {1'b1, PW'(770 * E10)})
    tally_and_finish();
  end
endmodule : tb

/* File: logic/ccb_pkg.sv */
// ccb_pkg: constants, types and register map of the block
////////////////////////
package ccb_pkg;
  // pressures are unsigned counts of 1e-10 torr
  localparam int PW = 48;
  typedef logic [PW-1:0] ccb_press_t;
  localparam logic [63:0] E4  = 64'h2710;
  localparam logic [63:0] E6  = 64'hf4240;
  localparam logic [63:0] E9  = 64'h3b9aca00;
  localparam logic [63:0] E10 = 64'h2540be400;
  localparam ccb_press_t CC_ON_RST    = PW'(5 * E6);
  localparam ccb_press_t CC_OFF_RST   = PW'(8 * E6);
  localparam ccb_press_t BLEND_LO_RST = PW'(E6);
  localparam ccb_press_t BLEND_HI_RST = PW'(4 * E6);
  localparam ccb_press_t SET_MIN      = PW'(E6);
  localparam ccb_press_t SET_MAX      = PW'(50 * E6);
  localparam ccb_press_t FORCE_OFF_P  = PW'(50 * E6);
  localparam ccb_press_t CAL_BELOW_P  = PW'(12 * E9);
  localparam ccb_press_t CAL_DELTA_P  = PW'(10 * E10);
  localparam ccb_press_t ATM_DEF_P    = PW'(760 * E10);
  localparam ccb_press_t DOSE_SP_RST  = PW'(E10);
  localparam ccb_press_t DOSE_SP_MIN  = PW'(E4);
  localparam ccb_press_t DOSE_SP_MAX  = PW'(100 * E10);
  localparam ccb_press_t GA_LO = PW'(40 * E10);
  localparam ccb_press_t GA_HI = PW'(60 * E10);
  localparam ccb_press_t GB_LO = PW'(5 * E10);
  localparam ccb_press_t GB_HI = PW'(7 * E10);
  localparam ccb_press_t GC_LO = PW'(7 * E10);
  localparam ccb_press_t GC_HI = PW'(10 * E10);
  localparam logic [16:0] UP30_MUL = 17'h14ccd; // 1.3 in 16 fraction bits
  localparam logic [23:0] INV_3600 = 24'h123456; // 2^32 / 3600
  localparam logic [9:0]  PROT_TIME_RST = 10'h078;
  localparam logic [9:0]  PROT_TIME_MAX = 10'h3e7;
  localparam logic [7:0]  REPLY_ACK = 8'h00;
  localparam logic [7:0]  NAK_RANGE = 8'hac;
  localparam logic [7:0]  NAK_AUTO  = 8'hc3;
  localparam logic [3:0]  DIG3 = 4'h3;
  localparam logic [3:0]  DIG4 = 4'h4;
  typedef enum logic [3:0] {
    GAS_NITROGEN, GAS_AIR, GAS_ARGON, GAS_HELIUM, GAS_HYDROGEN,
    GAS_H2O, GAS_NEON, GAS_CO2, GAS_XENON
  } ccb_gas_e;
  localparam logic [3:0] GAS_MAX = 4'h8;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_REPLY   = 8'h08;
  localparam logic [7:0] REG_GAS     = 8'h0c;
  localparam logic [7:0] REG_PROT    = 8'h10;
  localparam logic [7:0] REG_STAGE   = 8'h14;
  localparam logic [7:0] REG_READ_HI = 8'h18;
  localparam logic [7:0] REG_CC_ON   = 8'h20;
  localparam logic [7:0] REG_CC_OFF  = 8'h24;
  localparam logic [7:0] REG_BLO     = 8'h28;
  localparam logic [7:0] REG_BHI     = 8'h2c;
  localparam logic [7:0] REG_DOSE_SP = 8'h30;
  localparam logic [7:0] REG_RD3     = 8'h34;
  localparam logic [7:0] REG_RD4     = 8'h38;
  localparam logic [7:0] REG_DOSE    = 8'h3c;
  localparam logic [7:0] REG_PABS    = 8'h40;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_MAN  = 1;
  localparam int CTRL_PROT = 2;
  // time base
  localparam int CLK_HZ            = 200_000_000;
  localparam int BLINK_HALF_MS     = 500;
  localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
  typedef struct packed {
    logic [PW-1:0]        thermal;
    logic [PW-1:0]        ion;
    logic signed [PW-1:0] piezo_diff;
    logic                 ion_ignited;
  } ccb_sense_s;
endpackage : ccb_pkg

/* File: logic/ccb_top.sv */
// ccb_top: cold cathode switching, reading blend, dose and wishbone registers
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module ccb_top #(
  parameter int unsigned HALF_CYCLES = ccb_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire ccb_pkg::ccb_sense_s sense_i,
  output logic                    cc_hv_en_o,
  output logic                    led_red_o,
  output logic                    led_green_o,
  output logic                    nvm_we_o,
  output ccb_pkg::ccb_press_t     nvm_data_o
);
  import ccb_pkg::*;

  if (HALF_CYCLES < 2) begin : g_chk
    $error("HALF_CYCLES must be at least 2");
  end

  ////////////////////////
  // state
  logic        auto_q, manual_q, prot_en_q, hv_q, trip_q;
  logic [3:0]  gas_q;
  logic [9:0]  prot_time_q, pcnt_q;
  logic [7:0]  reply_q;
  logic [31:0] stage_q, read_hi_q, tcnt_q;
  ccb_press_t  on_q, off_q, blo_q, bhi_q, dose_sp_q, comb_q, cal_q, stored_q, dose_h_q;
  logic        cal_valid_q, stored_valid_q, dose_over_q, blink_q, half_q, sec_q;
  logic [63:0] dose_acc_q;
  logic [PW-1:0] rem_q, den_q;
  logic [15:0] quo_q;
  logic [4:0]  dcnt_q;
  logic        job_q;
  logic [16:0] w_ion_q, w_gas_q;

  ////////////////////////
  // combinational helpers
  ccb_press_t th, ion, pabs, glo, ghi, gsel, low, comb_d, wval, bhi_auto;
  ccb_press_t num_c, den_c, newcal, cal_delta;
  logic signed [PW+1:0] pabs_s;
  logic signed [PW:0]   d1, d2;
  logic signed [PW+18:0] p1, p2;
  logic [PW:0]  rem2;
  logic         qbit, ion_ok, grp_a, grp_b, hv_req, hv_d;
  logic         wb_req, wr, wr_ctrl;
  logic [PW+16:0] up30;
  logic [87:0]  dose_prod;

  assign th  = sense_i.thermal;
  assign ion = sense_i.ion;

  // ion valid while hv runs and ignited
  assign ion_ok = hv_q & sense_i.ion_ignited;

  // piezo absolute from calibration or default
  assign pabs_s = $signed({2'b00, (cal_valid_q ? cal_q : ATM_DEF_P)}) + sense_i.piezo_diff;
  assign pabs   = pabs_s[PW+1] ? '0 : pabs_s[PW-1:0];

  // gas group picks band edges and reading
  assign grp_a = (gas_q == GAS_NITROGEN) | (gas_q == GAS_AIR) | (gas_q == GAS_NEON) |
                 (gas_q == GAS_CO2) | (gas_q == GAS_XENON);
  assign grp_b = (gas_q == GAS_HYDROGEN);
  assign glo   = grp_a ? GA_LO : (grp_b ? GB_LO : GC_LO);
  assign ghi   = grp_a ? GA_HI : (grp_b ? GB_HI : GC_HI);
  assign gsel  = grp_a ? th : pabs;

  // divider operands, alternating per weight
  always_comb begin
    if (!job_q) begin
      num_c = th - blo_q;
      den_c = bhi_q - blo_q;
    end else begin
      num_c = gsel - glo;
      den_c = ghi - glo;
    end
  end
  assign rem2 = {rem_q, 1'b0};
  assign qbit = (rem2 >= {1'b0, den_q});

  // blend thermal/ion, then low range/piezo
  always_comb begin
    d1 = $signed({1'b0, th}) - $signed({1'b0, ion});
    p1 = d1 * $signed({1'b0, w_ion_q});
    if (!ion_ok || th >= bhi_q) begin
      low = th;
    end else if (th <= blo_q) begin
      low = ion;
    end else begin
      low = PW'($signed({1'b0, ion}) + (p1 >>> 16));
    end
    d2 = $signed({1'b0, pabs}) - $signed({1'b0, low});
    p2 = d2 * $signed({1'b0, w_gas_q});
    if (gsel < glo) begin
      comb_d = low;
    end else if (gsel > ghi) begin
      comb_d = pabs;
    end else begin
      comb_d = PW'($signed({1'b0, low}) + (p2 >>> 16));
    end
  end

  // hv request: hysteresis or manual, forced off
  always_comb begin
    if (auto_q) begin
      if (th < on_q) begin
        hv_req = 1'b1;
      end else if (th > off_q) begin
        hv_req = 1'b0;
      end else begin
        hv_req = hv_q;
      end
    end else begin
      hv_req = manual_q;
    end
    hv_d = hv_req & ~(th > FORCE_OFF_P) & ~trip_q;
  end

  // bus decode and derived values
  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = wb_req & wb_we_i & (wb_sel_i == 4'hf);
  assign wr_ctrl   = wr & (wb_adr_i == REG_CTRL);
  assign wval      = {wb_dat_i[15:0], stage_q};
  assign up30      = wval * UP30_MUL;
  assign bhi_auto  = up30[PW+15:16];
  assign newcal    = sense_i.piezo_diff[PW-1] ? PW'(-sense_i.piezo_diff) : '0;
  assign cal_delta = (newcal > stored_q) ? newcal - stored_q : stored_q - newcal;
  assign dose_prod = dose_acc_q * INV_3600;

  ////////////////////////
  // half second divider, blink phase and one second tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcnt_q  <= '0;
      half_q  <= 1'b0;
      blink_q <= 1'b0;
      sec_q   <= 1'b0;
    end else begin
      half_q <= 1'b0;
      sec_q  <= half_q & blink_q;
      if (tcnt_q == 32'(HALF_CYCLES - 1)) begin
        tcnt_q  <= '0;
        half_q  <= 1'b1;
        blink_q <= ~blink_q;
      end else begin
        tcnt_q <= tcnt_q + 32'h1;
      end
    end
  end

  // serial divider for 16 bit blend weights
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem_q   <= '0;
      den_q   <= '0;
      quo_q   <= '0;
      dcnt_q  <= '0;
      job_q   <= 1'b0;
      w_ion_q <= '0;
      w_gas_q <= '0;
    end else if (dcnt_q == 5'h0) begin
      rem_q  <= num_c;
      den_q  <= den_c;
      quo_q  <= '0;
      dcnt_q <= 5'h10;
    end else begin
      rem_q  <= qbit ? PW'(rem2 - {1'b0, den_q}) : rem2[PW-1:0];
      quo_q  <= {quo_q[14:0], qbit};
      dcnt_q <= dcnt_q - 5'h1;
      if (dcnt_q == 5'h1) begin
        job_q <= ~job_q;
        if (job_q) begin
          w_gas_q <= {1'b0, quo_q[14:0], qbit};
        end else begin
          w_ion_q <= {1'b0, quo_q[14:0], qbit};
        end
      end
    end
  end

  // combined reading register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comb_q <= '0;
    end else begin
      comb_q <= comb_d;
    end
  end

  // hv state and status led
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_q        <= 1'b0;
      cc_hv_en_o  <= 1'b0;
      led_red_o   <= 1'b0;
      led_green_o <= 1'b0;
    end else begin
      hv_q        <= hv_d;
      cc_hv_en_o  <= hv_d;
      led_red_o   <= hv_q & ~ion_ok & blink_q;
      led_green_o <= ion_ok & blink_q;
    end
  end

  // protect timer; a new trip wins over a control write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcnt_q <= '0;
      trip_q <= 1'b0;
    end else begin
      if (!prot_en_q || !ion_ok || ion <= FORCE_OFF_P) begin
        pcnt_q <= '0;
        if (wr_ctrl) begin
          trip_q <= 1'b0;
        end
      end else if (sec_q) begin
        pcnt_q <= pcnt_q + 10'h1;
        if (pcnt_q + 10'h1 >= prot_time_q) begin
          trip_q <= 1'b1;
        end else if (wr_ctrl) begin
          trip_q <= 1'b0;
        end
      end else if (wr_ctrl) begin
        trip_q <= 1'b0;
      end
    end
  end

  // dose in 1e-10 torr seconds, scaled to 1e-10 torr hours
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dose_acc_q  <= '0;
      dose_h_q    <= '0;
      dose_over_q <= 1'b0;
    end else begin
      if (sec_q && hv_q) begin
        dose_acc_q <= dose_acc_q + {16'h0, comb_q};
      end
      dose_h_q    <= dose_prod[PW+31:32];
      dose_over_q <= (dose_h_q > dose_sp_q);
    end
  end

  // piezo calibration when pumped down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_q          <= '0;
      cal_valid_q    <= 1'b0;
      stored_q       <= '0;
      stored_valid_q <= 1'b0;
      nvm_we_o       <= 1'b0;
      nvm_data_o     <= '0;
    end else begin
      nvm_we_o <= 1'b0;
      if (sec_q && th < CAL_BELOW_P) begin
        cal_q       <= newcal;
        cal_valid_q <= 1'b1;
        if (!stored_valid_q || cal_delta > CAL_DELTA_P) begin
          stored_q       <= newcal;
          stored_valid_q <= 1'b1;
          nvm_we_o       <= 1'b1;
          nvm_data_o     <= newcal;
        end
      end
    end
  end

  // register writes with reply code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_q      <= 1'b1;
      manual_q    <= 1'b0;
      prot_en_q   <= 1'b0;
      prot_time_q <= PROT_TIME_RST;
      gas_q       <= 4'h0;
      stage_q     <= '0;
      on_q        <= CC_ON_RST;
      off_q       <= CC_OFF_RST;
      blo_q       <= BLEND_LO_RST;
      bhi_q       <= BLEND_HI_RST;
      dose_sp_q   <= DOSE_SP_RST;
      reply_q     <= REPLY_ACK;
    end else if (wr) begin
      reply_q <= REPLY_ACK;
      case (wb_adr_i)
        REG_CTRL: begin
          auto_q    <= wb_dat_i[CTRL_AUTO];
          prot_en_q <= wb_dat_i[CTRL_PROT];
          if (wb_dat_i[CTRL_AUTO] && wb_dat_i[CTRL_MAN] != manual_q) begin
            reply_q <= NAK_AUTO;
          end else begin
            manual_q <= wb_dat_i[CTRL_MAN];
          end
        end
        REG_GAS: begin
          if (wb_dat_i[3:0] > GAS_MAX || wb_dat_i[31:4] != 28'h0) begin
            reply_q <= NAK_RANGE;
          end else begin
            gas_q <= wb_dat_i[3:0];
          end
        end
        REG_PROT: begin
          if (wb_dat_i[9:0] > PROT_TIME_MAX || wb_dat_i[31:10] != 22'h0) begin
            reply_q <= NAK_RANGE;
          end else begin
            prot_time_q <= wb_dat_i[9:0];
          end
        end
        REG_STAGE: begin
          stage_q <= wb_dat_i;
        end
        REG_CC_ON: begin
          if (!auto_q) begin
            reply_q <= NAK_AUTO;
          end else if (wval < SET_MIN || wval > SET_MAX) begin
            reply_q <= NAK_RANGE;
          end else begin
            on_q <= wval;
          end
        end
        REG_CC_OFF: begin
          if (!auto_q) begin
            reply_q <= NAK_AUTO;
          end else if (wval <= on_q || wval < SET_MIN || wval > SET_MAX) begin
            reply_q <= NAK_RANGE;
          end else begin
            off_q <= wval;
          end
        end
        REG_BLO: begin
          if (wval < SET_MIN || wval > bhi_q) begin
            reply_q <= NAK_RANGE;
          end else begin
            blo_q <= wval;
            bhi_q <= bhi_auto;
          end
        end
        REG_BHI: begin
          if (wval < SET_MIN || wval > SET_MAX) begin
            reply_q <= NAK_RANGE;
          end else begin
            bhi_q <= wval;
          end
        end
        REG_DOSE_SP: begin
          if (wval < DOSE_SP_MIN || wval > DOSE_SP_MAX) begin
            reply_q <= NAK_RANGE;
          end else begin
            dose_sp_q <= wval;
          end
        end
        default: begin
          reply_q <= REPLY_ACK;
        end
      endcase
    end
  end

  // read data, upper word and one cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= '0;
      read_hi_q <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= '0;
        case (wb_adr_i)
          REG_CTRL:    wb_dat_o <= {29'h0, prot_en_q, manual_q, auto_q};
          REG_STATUS:  wb_dat_o <= {27'h0, trip_q, cal_valid_q, dose_over_q, ion_ok, hv_q};
          REG_REPLY:   wb_dat_o <= {24'h0, reply_q};
          REG_GAS:     wb_dat_o <= {28'h0, gas_q};
          REG_PROT:    wb_dat_o <= {22'h0, prot_time_q};
          REG_STAGE:   wb_dat_o <= stage_q;
          REG_READ_HI: wb_dat_o <= read_hi_q;
          REG_CC_ON: begin
            wb_dat_o  <= on_q[31:0];
            read_hi_q <= {16'h0, on_q[PW-1:32]};
          end
          REG_CC_OFF: begin
            wb_dat_o  <= off_q[31:0];
            read_hi_q <= {16'h0, off_q[PW-1:32]};
          end
          REG_BLO: begin
            wb_dat_o  <= blo_q[31:0];
            read_hi_q <= {16'h0, blo_q[PW-1:32]};
          end
          REG_BHI: begin
            wb_dat_o  <= bhi_q[31:0];
            read_hi_q <= {16'h0, bhi_q[PW-1:32]};
          end
          REG_DOSE_SP: begin
            wb_dat_o  <= dose_sp_q[31:0];
            read_hi_q <= {16'h0, dose_sp_q[PW-1:32]};
          end
          REG_RD3: begin
            wb_dat_o  <= comb_q[31:0];
            read_hi_q <= {12'h0, DIG3, comb_q[PW-1:32]};
          end
          REG_RD4: begin
            wb_dat_o  <= comb_q[31:0];
            read_hi_q <= {12'h0, DIG4, comb_q[PW-1:32]};
          end
          REG_DOSE: begin
            wb_dat_o  <= dose_h_q[31:0];
            read_hi_q <= {16'h0, dose_h_q[PW-1:32]};
          end
          REG_PABS: begin
            wb_dat_o  <= pabs[31:0];
            read_hi_q <= {16'h0, pabs[PW-1:32]};
          end
          default:     wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule : ccb_top
